// ### shared/result_mem_if.sv
// result word store connection between capture core and memory
interface result_mem_if;
  logic        wr_en;
  logic [3:0]  wr_addr;
  logic [15:0] wr_data;
  logic [3:0]  rd_addr;
  logic [15:0] rd_data;
  modport store (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
  modport core (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
endinterface : result_mem_if

// ### shared/self_test_pkg.sv
// constants and types shared by the self test unit files
package self_test_pkg;

  // ****************
  // clocking
  // ****************
  localparam int         CLK_MHZ        = 200;
  localparam int         UNIT_MHZ       = 16;
  localparam logic [7:0] ACC_WRAP       = 8'(CLK_MHZ);
  localparam logic [7:0] UNIT_STEP      = 8'(UNIT_MHZ);

  // ****************
  // reply timing
  // ****************
  localparam int          ATC_BIT_NS     = 1450;
  localparam int          ATC_FIRST_NS   = 250;
  localparam int          DABS_CHIP_NS   = 500;
  localparam int          DABS_PRE_NS    = 8000;
  localparam logic [10:0] ATC_BIT_CYC    = 11'(ATC_BIT_NS * CLK_MHZ / 1000);
  localparam logic [10:0] ATC_FIRST_CYC  = 11'(ATC_FIRST_NS * CLK_MHZ / 1000);
  localparam logic [10:0] DABS_CHIP_CYC  = 11'(DABS_CHIP_NS * CLK_MHZ / 1000);
  localparam logic [10:0] DABS_FIRST_CYC =
    11'((DABS_PRE_NS + DABS_CHIP_NS / 2) * CLK_MHZ / 1000);
  localparam logic [5:0]  ATC_BITS       = 6'h0f;
  localparam logic [5:0]  DABS_BITS      = 6'h38;

  // ****************
  // control word fields
  // ****************
  localparam int          TYPE_LSB       = 0;
  localparam int          CHAN_LSB       = 4;
  localparam int          MODE_BIT       = 6;
  localparam logic [1:0]  CHAN_SUM       = 2'h1;
  localparam logic [1:0]  CHAN_DIFF      = 2'h2;
  localparam logic [1:0]  CHAN_OMEGA     = 2'h3;
  localparam logic [3:0]  TYPE_OFF       = 4'h0;
  localparam logic [3:0]  DABS_TYPE_MIN  = 4'h8;
  localparam logic [15:0] CTRL1_RST      = 16'h0000;
  localparam logic [15:0] CTRL2_RST      = 16'h0000;
  localparam logic [7:0]  AMP_NEAR_MAX   = 8'he0;

  // ****************
  // result words
  // ****************
  localparam logic [3:0]  RES_LAST       = 4'ha;
  localparam int          RES_WORDS      = 11;

  typedef enum logic [1:0] {CAP_IDLE, CAP_WAIT, CAP_SAMPLE, CAP_STORE} cap_state_t;

endpackage : self_test_pkg

// ### test/beacon_self_test_unit_bench.sv
// self checking bench for the self test unit
module beacon_self_test_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk;
  logic        arst_n;
  logic        wr_a;
  logic [15:0] wr_data;
  logic        rd_a;
  logic [15:0] rd_data;
  logic        start;
  logic        clear_cmd;
  logic        int_disable;
  logic        range_zero;
  logic        reply_sum;
  logic        reply_diff;
  logic        reply_omega;
  logic        left;
  logic [7:0]  amp_sum;
  logic [7:0]  amp_diff;
  logic [7:0]  amp_omega;
  logic        fire;
  logic [3:0]  itype;
  logic        busy;
  logic        done;
  logic        irq;
  int          err_count;
  int          checks_done;
  int          cyc = 0;
  logic [15:0] res [0:12];
  logic [15:0] t_fire;

  self_test_unit i_self_test_unit (.MCLK(mclk), .ARST_N(arst_n), .WR_A(wr_a),
    .WR_DATA(wr_data), .RD_A(rd_a), .RD_DATA(rd_data), .START(start),
    .CLEAR_CMD(clear_cmd), .INT_DISABLE(int_disable), .RANGE_ZERO(range_zero),
    .REPLY_SUM(reply_sum), .REPLY_DIFF(reply_diff), .REPLY_OMEGA(reply_omega),
    .LEFT_OF_BORESIGHT(left), .AMP_SUM(amp_sum), .AMP_DIFF(amp_diff),
    .AMP_OMEGA(amp_omega), .INTERROG_FIRE(fire), .INTERROG_TYPE(itype),
    .BUSY(busy), .DONE(done), .IRQ(irq));

  reply_source i_reply_source (.clk(mclk), .reply_sum(reply_sum),
    .reply_diff(reply_diff), .reply_omega(reply_omega), .amp_sum(amp_sum),
    .amp_diff(amp_diff), .amp_omega(amp_omega), .left(left));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk)
    cyc <= arst_n ? cyc + 1 : 0;

  // ****************
  // helpers
  // ****************
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check16

  task automatic check1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check1

  // unit clock estimate: 16 ticks per 200 cycles
  function automatic logic [15:0] t_ahead(input int n);
    return 16'(cyc * 2 / 25 + n);
  endfunction : t_ahead

  task automatic wr_word(input logic [15:0] d);
    @(posedge mclk);
    wr_a    <= 1'b1;
    wr_data <= d;
    @(posedge mclk);
    wr_a <= 1'b0;
  endtask : wr_word

  task automatic wr_pair(input logic [15:0] a, input logic [15:0] b);
    @(posedge mclk);
    wr_a    <= 1'b1;
    wr_data <= a;
    @(posedge mclk);
    wr_data <= b;
    @(posedge mclk);
    wr_a <= 1'b0;
  endtask : wr_pair

  task automatic rd_words(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk);
      rd_a <= 1'b1;
      @(posedge mclk);
      rd_a <= 1'b0;
      @(posedge mclk);
      #1;
      res[i] = rd_data;
    end
  endtask : rd_words

  task automatic pulse_start();
    @(posedge mclk);
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
  endtask : pulse_start

  task automatic no_fire(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      check1(fire, 1'b0);
    end
  endtask : no_fire

  task automatic wait_on(input logic want_done);
    int k;
    k = 0;
    #1;
    while ((want_done ? done : fire) !== 1'b1 && k < 20000)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k == 20000)
    begin
      err_count++;
      print_verdict();
    end
  endtask : wait_on

  // ****************
  // scenarios
  // ****************
  task automatic test_reset();
    check1(fire, 1'b0);
    check1(busy, 1'b0);
    check1(done, 1'b0);
    check1(irq, 1'b0);
    check16({12'h000, itype}, 16'h0000);
    check16(rd_data, 16'h0000);
  endtask : test_reset

  task automatic test_generator();
    @(posedge mclk);
    range_zero <= 1'b0;
    wr_pair(t_ahead(40), 16'h0000);
    no_fire(900);
    wr_pair(t_ahead(0) - 16'h0100, 16'h0002);
    t_fire = t_ahead(150);
    wr_word(t_fire);
    no_fire(800);
    wr_word(16'h0003);
    wait_on(1'b0);
    check16({12'h000, itype}, 16'h0003);
    check1(busy, 1'b0);
    check1(done, 1'b0);
    no_fire(1);
    wr_pair(t_ahead(60), 16'h0009);
    @(posedge mclk);
    clear_cmd <= 1'b1;
    @(posedge mclk);
    clear_cmd <= 1'b0;
    no_fire(1100);
  endtask : test_generator

  task automatic test_atcrbs();
    wr_pair(16'h1234, 16'h0010);
    i_reply_source.send(2'h1, 1'b0, 56'h5a5b, -1, 24'hf0f011, 1'b1);
    #1;
    check1(busy, 1'b0);
    check1(done, 1'b0);
    @(posedge mclk);
    int_disable <= 1'b1;
    pulse_start();
    #1;
    check1(busy, 1'b1);
    check1(done, 1'b0);
    i_reply_source.send(2'h3, 1'b0, 56'h7fff, -1, 24'h101010, 1'b0);
    #1;
    check1(busy, 1'b1);
    i_reply_source.send(2'h1, 1'b0, 56'h5a5b, -1, 24'hf0f011, 1'b1);
    wait_on(1'b1);
    check1(busy, 1'b0);
    no_fire(3);
    check1(irq, 1'b0);
    @(posedge mclk);
    int_disable <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check1(irq, 1'b1);
    rd_words(11);
    check16(res[0], res[9] - t_fire - 16'h0001);
    check16(res[1], 16'hc0f0);
    check16(res[5] & 16'h7fff, 16'h5a5b);
    check16(res[6], 16'h1234);
    check16(res[7], 16'h0010);
    check16(res[8], 16'h000f);
  endtask : test_atcrbs

  task automatic test_dabs();
    @(posedge mclk);
    range_zero <= 1'b1;
    wr_pair(16'h5678, 16'h0060);
    pulse_start();
    i_reply_source.send(2'h2, 1'b1, 56'hc5a39ee17b2d04, 20, 24'h305577, 1'b1);
    wait_on(1'b1);
    rd_words(13);
    check1(irq, 1'b1);
    check16(res[0], 16'h0000);
    check16(res[1] & 16'h7fff, 16'h2055);
    check16(res[2] & 16'h00ff, 16'h00c5);
    check16(res[3], 16'ha396);
    check16(res[4], 16'he17b);
    check16(res[5], 16'h2d04);
    check16(res[6], 16'h5678);
    check16(res[7], 16'h0060);
    check16(res[8], 16'h0038);
    check16(res[12] & 16'h7fff, 16'h2055);
  endtask : test_dabs

  task automatic test_omega();
    wr_pair(16'h0000, 16'h0030);
    pulse_start();
    i_reply_source.send(2'h3, 1'b0, 56'h4321, -1, 24'h1122e5, 1'b0);
    wait_on(1'b1);
    rd_words(8);
    check16(res[0], 16'h0000);
    check16(res[1], 16'h00e5);
    check16(res[5] & 16'h7fff, 16'h4321);
    check16(res[7], 16'h0030);
  endtask : test_omega

  initial
  begin
    {arst_n, wr_a, rd_a, start, clear_cmd, int_disable} = 6'h00;
    wr_data = 16'h0000;
    range_zero = 1'b1;
    err_count = 0;
    checks_done = 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    test_reset();
    test_generator();
    test_atcrbs();
    test_dabs();
    test_omega();
    print_verdict();
  end
endmodule : beacon_self_test_unit_bench

// ### test/reply_source.sv
// reply video and amplitude source standing in for the if combiner
module reply_source (
  input  logic       clk,
  output logic       reply_sum,
  output logic       reply_diff,
  output logic       reply_omega,
  output logic [7:0] amp_sum,
  output logic [7:0] amp_diff,
  output logic [7:0] amp_omega,
  output logic       left
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {reply_sum, reply_diff, reply_omega, left} = 4'h0;
    {amp_sum, amp_diff, amp_omega} = 24'h000000;
  end

  // one whole reply per call, never overlapping
  task automatic send(input logic [1:0] ch, input logic dabs, input logic [55:0] d,
                      input int bad, input logic [23:0] amps, input logic lr);
    int   len;
    int   j;
    int   o;
    logic lvl;
    len = dabs ? 12800 : 4350;
    @(posedge clk);
    {amp_sum, amp_diff, amp_omega} <= amps;
    left <= lr;
    repeat (4) @(posedge clk);
    for (int t = 0; t < len; t++)
    begin
      j = t / 290;
      o = t % 290;
      if (!dabs)
        lvl = o < 90 && d[14 - j];
      else if (t < 1600)
        lvl = t < 100 || (t >= 200 && t < 300) || (t >= 700 && t < 800) || (t >= 900 && t < 1000);
      else
        lvl = ((t - 1600) / 200 != bad) && (((t - 1600) % 200 < 100) == d[55 - (t - 1600) / 200]);
      reply_sum   <= lvl && ch == self_test_pkg::CHAN_SUM;
      reply_diff  <= lvl && ch == self_test_pkg::CHAN_DIFF;
      reply_omega <= lvl && ch == self_test_pkg::CHAN_OMEGA;
      @(posedge clk);
    end
    {reply_sum, reply_diff, reply_omega} <= 3'h0;
    // converter output drifts once the reply is gone
    {amp_sum, amp_diff, amp_omega} <= ~amps;
    left <= ~lr;
  endtask : send
endmodule : reply_source

// ### verilog/input_sync.sv
// two flop synchroniser for pin inputs
module input_sync #(
  parameter int W = 1
) (
  input  logic         clk,
  input  logic         arst_n,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t r;
  sync_t next_r;

  always_comb
  begin
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign q = r.s2;
endmodule : input_sync

// ### verilog/result_mem.sv
// eleven word result store with registered read
module result_mem (
  input logic            clk,
  input logic            arst_n,
  result_mem_if.store    mem
);
  typedef struct packed {
    logic [self_test_pkg::RES_WORDS-1:0][15:0] word;
    logic [15:0]                               rdata;
  } store_t;

  store_t r;
  store_t next_r;

  always_comb
  begin
    next_r = r;
    if (mem.wr_en && mem.wr_addr <= self_test_pkg::RES_LAST)
      next_r.word[mem.wr_addr] = mem.wr_data;
    if (mem.rd_addr <= self_test_pkg::RES_LAST)
      next_r.rdata = r.word[mem.rd_addr];
    else
      next_r.rdata = 16'h0000;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign mem.rd_data = r.rdata;
endmodule : result_mem

// ### verilog/self_test_unit.sv
// self test unit: interrogation generator and single reply capture
module self_test_unit (
  input  logic        MCLK,
  input  logic        ARST_N,
  input  logic        WR_A,
  input  logic [15:0] WR_DATA,
  input  logic        RD_A,
  output logic [15:0] RD_DATA,
  input  logic        START,
  input  logic        CLEAR_CMD,
  input  logic        INT_DISABLE,
  input  logic        RANGE_ZERO,
  input  logic        REPLY_SUM,
  input  logic        REPLY_DIFF,
  input  logic        REPLY_OMEGA,
  input  logic        LEFT_OF_BORESIGHT,
  input  logic [7:0]  AMP_SUM,
  input  logic [7:0]  AMP_DIFF,
  input  logic [7:0]  AMP_OMEGA,
  output logic        INTERROG_FIRE,
  output logic [3:0]  INTERROG_TYPE,
  output logic        BUSY,
  output logic        DONE,
  output logic        IRQ
);
  localparam int SYNC_W = 29;

  typedef struct packed {
    logic                     wr_second;
    logic [15:0]              pend1;
    logic [15:0]              ctrl1;
    logic [15:0]              ctrl2;
    logic                     gen_en;
    logic [7:0]               acc;
    logic [15:0]              unit_clk;
    logic [15:0]              range_clk;
    logic                     fire;
    logic [3:0]               fire_type;
    self_test_pkg::cap_state_t cap;
    logic [10:0]              cnt;
    logic [5:0]               nbits;
    logic                     chip;
    logic                     first_chip;
    logic                     prev_pulse;
    logic [63:0]              bits;
    logic [15:0]              toa;
    logic [15:0]              arr_unit;
    logic [7:0]               amp;
    logic                     lr;
    logic                     lr_valid;
    logic                     err;
    logic [7:0]               edges;
    logic [3:0]               wptr;
    logic [3:0]               rptr;
    logic [15:0]              rd_data;
    logic                     busy;
    logic                     done;
    logic                     irq;
  } core_t;

  core_t              r;
  core_t              next_r;
  logic [SYNC_W-1:0]  sync_q;
  logic               range_zero_s;
  logic [2:0]         pulse_s;
  logic               lob_s;
  logic [7:0]         amp_sum_s;
  logic [7:0]         amp_diff_s;
  logic [7:0]         amp_omega_s;
  logic               pulse;
  logic               rise;
  logic [7:0]         amp_sel;
  logic               dabs;
  logic [3:0]         itype;
  logic [7:0]         acc_sum;
  logic               tick;

  result_mem_if mif ();

  // ****************
  // pin synchronisers and result store
  // ****************
  input_sync #(.W(SYNC_W)) u_sync (
    .clk    (MCLK),
    .arst_n (ARST_N),
    .d      ({RANGE_ZERO, REPLY_SUM, REPLY_DIFF, REPLY_OMEGA, LEFT_OF_BORESIGHT,
              AMP_SUM, AMP_DIFF, AMP_OMEGA}),
    .q      (sync_q)
  );

  assign {range_zero_s, pulse_s, lob_s, amp_sum_s, amp_diff_s, amp_omega_s} = sync_q;

  result_mem u_mem (
    .clk    (MCLK),
    .arst_n (ARST_N),
    .mem    (mif.store)
  );

  // ****************
  // decoding helpers
  // ****************
  function automatic logic [15:0] result_word(input core_t s, input logic [3:0] idx);
    case (idx)
      4'h0:    result_word = s.toa;
      4'h1:    result_word = {s.lr, s.lr_valid, s.err, 5'h00, s.amp};
      4'h2:    result_word = s.bits[63:48];
      4'h3:    result_word = s.bits[47:32];
      4'h4:    result_word = s.bits[31:16];
      4'h5:    result_word = s.bits[15:0];
      4'h6:    result_word = s.ctrl1;
      4'h7:    result_word = s.ctrl2;
      4'h8:    result_word = {10'h000, s.nbits};
      4'h9:    result_word = s.arr_unit;
      4'ha:    result_word = {8'h00, s.edges};
      default: result_word = 16'h0000;
    endcase
  endfunction : result_word

  function automatic logic [7:0] pick(input logic [1:0] ch, input logic [7:0] a,
                                      input logic [7:0] b, input logic [7:0] c);
    case (ch)
      self_test_pkg::CHAN_SUM:   pick = a;
      self_test_pkg::CHAN_DIFF:  pick = b;
      self_test_pkg::CHAN_OMEGA: pick = c;
      default:                   pick = 8'h00;
    endcase
  endfunction : pick

  always_comb
  begin
    itype   = r.ctrl2[self_test_pkg::TYPE_LSB +: 4];
    dabs    = r.ctrl2[self_test_pkg::MODE_BIT];
    amp_sel = pick(r.ctrl2[self_test_pkg::CHAN_LSB +: 2], amp_sum_s, amp_diff_s, amp_omega_s);
    pulse   = |pick(r.ctrl2[self_test_pkg::CHAN_LSB +: 2], {7'h00, pulse_s[2]},
                    {7'h00, pulse_s[1]}, {7'h00, pulse_s[0]});
    rise    = pulse && !r.prev_pulse;
    acc_sum = r.acc + self_test_pkg::UNIT_STEP;
    tick    = acc_sum >= self_test_pkg::ACC_WRAP;
  end

  // ****************
  // next state
  // ****************
  always_comb
  begin
    next_r = r;
    next_r.fire = 1'b0;
    next_r.prev_pulse = pulse;
    mif.wr_en = 1'b0;
    mif.wr_addr = r.wptr;
    mif.wr_data = result_word(r, r.wptr);
    mif.rd_addr = r.rptr;

    // control word pair
    if (WR_A)
    begin
      if (!r.wr_second)
      begin
        next_r.pend1 = WR_DATA;
        next_r.wr_second = 1'b1;
      end
      else
      begin
        next_r.ctrl1 = r.pend1;
        next_r.ctrl2 = WR_DATA;
        next_r.wr_second = 1'b0;
        next_r.gen_en = 1'b1;
      end
    end
    if (CLEAR_CMD)
      next_r.gen_en = 1'b0;

    // unit clock at 16 MHz from fractional accumulator
    next_r.acc = tick ? acc_sum - self_test_pkg::ACC_WRAP : acc_sum;
    next_r.unit_clk = r.unit_clk + {15'h0000, tick};
    if (tick && r.gen_en && itype != self_test_pkg::TYPE_OFF
        && r.unit_clk == r.ctrl1)
    begin
      next_r.fire = 1'b1;
      next_r.fire_type = itype;
    end

    // range clock
    if ((next_r.fire && itype < self_test_pkg::DABS_TYPE_MIN) || range_zero_s)
      next_r.range_clk = 16'h0000;
    else
      next_r.range_clk = r.range_clk + {15'h0000, tick};

    // reply capture
    case (r.cap)
      self_test_pkg::CAP_IDLE:
        next_r.cap = self_test_pkg::CAP_IDLE;
      self_test_pkg::CAP_WAIT:
        if (rise)
        begin
          next_r.toa = r.range_clk;
          next_r.arr_unit = r.unit_clk;
          next_r.amp = amp_sel;
          next_r.lr = lob_s;
          next_r.lr_valid = amp_sum_s == amp_diff_s && amp_sum_s >= self_test_pkg::AMP_NEAR_MAX;
          next_r.cnt = dabs ? self_test_pkg::DABS_FIRST_CYC : self_test_pkg::ATC_FIRST_CYC;
          next_r.nbits = 6'h00;
          next_r.chip = 1'b0;
          next_r.edges = 8'h01;
          next_r.cap = self_test_pkg::CAP_SAMPLE;
        end
      self_test_pkg::CAP_SAMPLE:
      begin
        if (rise)
          next_r.edges = r.edges + 8'h01;
        if (r.cnt != 11'h000)
          next_r.cnt = r.cnt - 11'h001;
        else if (!dabs)
        begin
          next_r.bits = {r.bits[62:0], pulse};
          next_r.nbits = r.nbits + 6'h01;
          next_r.cnt = self_test_pkg::ATC_BIT_CYC - 11'h001;
          if (r.nbits == self_test_pkg::ATC_BITS - 6'h01)
            next_r.cap = self_test_pkg::CAP_STORE;
        end
        else if (!r.chip)
        begin
          next_r.first_chip = pulse;
          next_r.chip = 1'b1;
          next_r.cnt = self_test_pkg::DABS_CHIP_CYC - 11'h001;
        end
        else
        begin
          next_r.bits = {r.bits[62:0], r.first_chip};
          if (r.first_chip == pulse)
            next_r.err = 1'b1;
          next_r.chip = 1'b0;
          next_r.nbits = r.nbits + 6'h01;
          next_r.cnt = self_test_pkg::DABS_CHIP_CYC - 11'h001;
          if (r.nbits == self_test_pkg::DABS_BITS - 6'h01)
            next_r.cap = self_test_pkg::CAP_STORE;
        end
        if (next_r.cap == self_test_pkg::CAP_STORE)
          next_r.wptr = 4'h0;
      end
      self_test_pkg::CAP_STORE:
      begin
        mif.wr_en = 1'b1;
        next_r.wptr = r.wptr + 4'h1;
        if (r.wptr == self_test_pkg::RES_LAST)
        begin
          next_r.cap = self_test_pkg::CAP_IDLE;
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
        end
      end
      default:
        next_r.cap = self_test_pkg::CAP_IDLE;
    endcase

    // result readout
    if (RD_A)
    begin
      next_r.rd_data = mif.rd_data;
      next_r.rptr = (r.rptr == self_test_pkg::RES_LAST) ? 4'h0 : r.rptr + 4'h1;
    end

    // start restarts capture
    if (START)
    begin
      next_r.cap = self_test_pkg::CAP_WAIT;
      next_r.busy = 1'b1;
      next_r.done = 1'b0;
      next_r.rptr = 4'h0;
      next_r.err = 1'b0;
      next_r.bits = 64'h0;
      next_r.edges = 8'h00;
    end

    next_r.irq = next_r.done && !INT_DISABLE;
  end

  always_ff @(posedge MCLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      r <= '0;
      r.ctrl1 <= self_test_pkg::CTRL1_RST;
      r.ctrl2 <= self_test_pkg::CTRL2_RST;
      r.cap <= self_test_pkg::CAP_IDLE;
    end
    else
      r <= next_r;
  end

  assign RD_DATA       = r.rd_data;
  assign INTERROG_FIRE = r.fire;
  assign INTERROG_TYPE = r.fire_type;
  assign BUSY          = r.busy;
  assign DONE          = r.done;
  assign IRQ           = r.irq;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  sequence s_second_write;
    WR_A && r.wr_second;
  endsequence
  sequence s_finish;
    r.cap == self_test_pkg::CAP_STORE && r.wptr == self_test_pkg::RES_LAST && !START;
  endsequence

  a_pair_load: assert property (s_second_write |=> r.ctrl2 == $past(WR_DATA)
    && r.ctrl1 == $past(r.pend1)) else $error("control pair not loaded");
  a_first_hold: assert property (WR_A && !r.wr_second |=> $stable(r.ctrl1)
    && $stable(r.ctrl2)) else $error("control changed on first word");
  a_fire_time: assert property (INTERROG_FIRE |-> $past(r.unit_clk) == $past(r.ctrl1)
    && INTERROG_TYPE == $past(itype)) else $error("interrogation off time");
  a_type_zero: assert property (itype == self_test_pkg::TYPE_OFF |=> !INTERROG_FIRE)
    else $error("interrogation with type zero");
  a_clear_stop: assert property (CLEAR_CMD |=> !r.gen_en ##1
    !INTERROG_FIRE) else $error("generation after clear");
  a_busy_cause: assert property ($rose(BUSY) |-> $past(START))
    else $error("busy without start");
  a_start_reset: assert property (START |=> BUSY && !DONE && r.rptr == 4'h0
    && r.cap == self_test_pkg::CAP_WAIT) else $error("start did not restart");
  a_done_set: assert property (s_finish |=> DONE && !BUSY)
    else $error("done not set at end");
  a_irq_pend: assert property (DONE && !INT_DISABLE && !START |=> IRQ)
    else $error("pending done not raised");
  a_range_zero: assert property (INTERROG_FIRE
    && INTERROG_TYPE < self_test_pkg::DABS_TYPE_MIN |-> r.range_clk == 16'h0000)
    else $error("range clock not zeroed");
  a_amp_sample: assert property (r.cap == self_test_pkg::CAP_WAIT && rise && !START
    |=> r.amp == $past(amp_sel) && r.cap == self_test_pkg::CAP_SAMPLE)
    else $error("amplitude not sampled");
  a_err_mode: assert property ($rose(r.err) |-> $past(dabs))
    else $error("error bit outside dabs mode");
endmodule : self_test_unit
